// ---- thermistor_temperature_readout.sv ----
// Temperature channel: thermistor sequencing, conversion, mean, peaks and APB registers.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module thermistor_temperature_readout #(
    parameter int unsigned CONV_TICKS = thermistor_pkg::CONV_CYCLES,
    parameter int unsigned SETTLE_TICKS = thermistor_pkg::SETTLE_CYCLES
) (
    input wire logic pclk, // System clock, 25 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [9:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data, registered.
    output logic pready, // APB ready, always high.
    output logic pslverr, // APB error, always low.
    input wire logic [15:0] aux_data, // Ratiometric aux converter result.
    output logic thermistor_bias_pin // High ties the divider to its supply.
);
    import thermistor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic [7:0] idx; // Word index of the access.
    logic wr_en; // Write takes effect this edge.
    logic rd_setup; // Read setup cycle.
    logic [15:0] wdata; // Low half of the write data.

    assign idx = paddr[9:2]; // R14
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wdata = pwdata[15:0];
    // Zero wait states, so the access phase always ends at once.
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [15:0] misc_rw [5]; // Alert status, limits and hypothetical load.
    logic [15:0] config_word; // Enable, external select and shutdown.
    logic [15:0] averaging_setup_word; // Mean window selection.
    logic [15:0] temp_gain_coef; // Signed conversion gain.
    logic [15:0] temp_offset_coef; // Signed conversion offset.
    logic [15:0] temperature; // Signed temperature word.
    logic [15:0] aux_ratio_result; // Last ratiometric sample.
    logic [31:0] mean_acc; // Mean with sixteen fraction bits.
    logic [7:0] temp_peak_high; // Highest whole-degree reading.
    logic [7:0] temp_peak_low; // Lowest whole-degree reading.
    logic seeded; // Mean has taken its first reading.

    logic ten; // Measurement enabled.
    logic tex; // Temperature is supplied by the host.
    logic shdn; // Block is in shutdown.

    assign ten = config_word[CFG_TEN_BIT];
    assign tex = config_word[CFG_TEX_BIT];
    assign shdn = config_word[CFG_SHDN_BIT];

    // Plain control words: write stores, reset loads the defaults.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                misc_rw[i] <= MISC_RESET[i]; // R16
            end
            config_word <= RST_CONFIG;
            averaging_setup_word <= RST_AVG_SETUP;
            temp_gain_coef <= RST_TEMP_GAIN;
            temp_offset_coef <= RST_TEMP_OFFSET;
        end else if (wr_en) begin
            // Reserved and read-only words simply ignore writes.
            if (idx <= IDX_HYP_LOAD) begin
                misc_rw[idx[2:0]] <= wdata;
            end else if (idx == IDX_CONFIG) begin
                config_word <= wdata;
            end else if (idx == IDX_AVG_SETUP) begin
                averaging_setup_word <= wdata;
            end else if (idx == IDX_TEMP_GAIN) begin
                temp_gain_coef <= wdata; // R13
            end else if (idx == IDX_TEMP_OFFSET) begin
                temp_offset_coef <= wdata; // R13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion period timer.

    logic [31:0] period_cnt; // Cycles into the current period.
    logic conv_start; // One-cycle start of a conversion.
    logic abort; // Sequence must stop at once.

    assign abort = shdn | ~ten; // R4
    assign conv_start = (period_cnt == CONV_TICKS - 1) & ~abort;

    // The timer freezes in shutdown so the cadence resumes where it left off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt <= '0;
        end else if (!shdn) begin
            if (period_cnt == CONV_TICKS - 1) begin
                period_cnt <= '0; // R3
            end else begin
                period_cnt <= period_cnt + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequence.

    conv_state_t state; // Present sequence state.
    conv_state_t next_state; // Following sequence state.
    logic [31:0] settle_cnt; // Cycles the divider has been biased.
    logic conv_fire; // Conversion result is applied this edge.

    assign conv_fire = (state == ST_CONV) & ~abort;

    // Bias first, wait for the divider to settle, sample, then convert.
    always_comb begin
        next_state = state;
        if (abort) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (conv_start) begin
                        next_state = ST_SETTLE; // R18
                    end
                end
                ST_SETTLE: begin
                    if (settle_cnt == SETTLE_TICKS - 1) begin
                        next_state = ST_SAMPLE; // R18
                    end
                end
                ST_SAMPLE: begin
                    next_state = ST_CONV;
                end
                ST_CONV: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // State and settle counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            settle_cnt <= '0;
        end else begin
            state <= next_state;
            if (state == ST_SETTLE) begin
                settle_cnt <= settle_cnt + 32'h1;
            end else begin
                settle_cnt <= '0;
            end
        end
    end

    // The divider draws current, so it is biased only while measuring.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thermistor_bias_pin <= 1'b0;
        end else begin
            thermistor_bias_pin <= (next_state == ST_SETTLE) |
                (next_state == ST_SAMPLE); // R18
        end
    end

    // Capture the aux sample; it holds at all other times.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_ratio_result <= RST_AUX_RATIO;
        end else if (state == ST_SAMPLE && !abort) begin
            aux_ratio_result <= aux_data; // R3 R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature arithmetic.

    logic signed [32:0] product; // Aux result times signed gain.
    logic [15:0] next_temp; // Converted temperature.

    // Aux is unsigned, so it gains a zero sign bit before the multiply.
    always_comb begin
        product = $signed({1'b0, aux_ratio_result}) * $signed(temp_gain_coef);
        next_temp = product[GAIN_SHIFT + 15:GAIN_SHIFT] +
            {temp_offset_coef[14:0], 1'b0}; // R13
    end

    logic temp_wr; // Host writes the temperature word.
    logic temp_upd; // Temperature word takes a new reading.
    logic [15:0] upd_val; // The new reading.

    assign temp_wr = wr_en & (idx == IDX_TEMPERATURE);
    assign temp_upd = (conv_fire & ~tex) | (temp_wr & ~shdn);
    assign upd_val = (conv_fire & ~tex) ? next_temp : wdata;

    // Conversion wins over a host write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temperature <= RST_TEMPERATURE;
        end else if (conv_fire && !tex) begin
            temperature <= next_temp; // R5 R7 R19
        end else if (temp_wr) begin
            temperature <= wdata; // R1 R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Running mean.

    logic [4:0] avg_shift; // Filter shift, eight to fifteen.
    logic signed [32:0] mean_diff; // New reading less the mean.
    logic signed [32:0] mean_step; // Scaled correction.

    // Shifts of 8..15 span about 6 minutes to 13 hours at 1.4 s a sample.
    always_comb begin
        avg_shift = AVG_SHIFT_BASE +
            {2'b00, averaging_setup_word[AVG_SHIFT_LSB + 2:AVG_SHIFT_LSB]};
        mean_diff = $signed({upd_val[15], upd_val, 16'h0000}) -
            $signed({mean_acc[31], mean_acc});
        mean_step = mean_diff >>> avg_shift; // R8
    end

    // The first reading loads the mean outright; shutdown freezes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mean_acc <= {RST_TEMPERATURE, 16'h0000};
            seeded <= 1'b0;
        end else if (temp_upd) begin
            seeded <= 1'b1;
            if (!seeded) begin
                mean_acc <= {upd_val, 16'h0000}; // R9
            end else begin
                mean_acc <= mean_acc + mean_step[31:0]; // R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peak record.

    logic peak_wr; // Host writes the peak record.
    logic [7:0] base_high; // High peak after any host write.
    logic [7:0] base_low; // Low peak after any host write.
    logic [7:0] upd_byte; // Whole-degree byte of the new reading.

    assign peak_wr = wr_en & (idx == IDX_PEAK_REC);
    assign base_high = peak_wr ? wdata[15:8] : temp_peak_high;
    assign base_low = peak_wr ? wdata[7:0] : temp_peak_low;
    assign upd_byte = upd_val[15:8]; // R6

    // A reading in the cycle of a clear is compared against the cleared value,
    // so the event is never lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_peak_high <= RST_PEAK_REC[15:8]; // R11
            temp_peak_low <= RST_PEAK_REC[7:0]; // R11
        end else begin
            temp_peak_high <= base_high;
            temp_peak_low <= base_low;
            if (temp_upd && $signed(upd_byte) > $signed(base_high)) begin
                temp_peak_high <= upd_byte; // R10 R12
            end
            if (temp_upd && $signed(upd_byte) < $signed(base_low)) begin
                temp_peak_low <= upd_byte; // R10 R12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [15:0] read_word; // Word selected by the address.

    // Gauge outputs outside this channel read their power-on values.
    always_comb begin
        read_word = RST_ZERO; // R17
        if (idx <= IDX_HYP_LOAD) begin
            read_word = misc_rw[idx[2:0]];
        end else begin
            case (idx)
                IDX_REM_CAP: read_word = RST_REM_CAP;
                IDX_CHG_PCT: read_word = RST_PCT;
                IDX_CELL_AGE: read_word = RST_CELL_AGE;
                IDX_TEMPERATURE: read_word = temperature;
                IDX_CELL_VOLT: read_word = RST_CELL_VOLT;
                IDX_SENSE_CUR: read_word = RST_ZERO;
                IDX_MEAN_CUR: read_word = RST_ZERO;
                IDX_BLEND_PCT: read_word = RST_PCT;
                IDX_AVAIL_PCT: read_word = RST_PCT;
                IDX_BLEND_CAP: read_word = RST_REM_CAP;
                IDX_TEMP_MEAN: read_word = mean_acc[31:16];
                IDX_PEAK_REC: read_word = {temp_peak_high, temp_peak_low}; // R12
                IDX_CONFIG: read_word = config_word;
                IDX_AUX_RATIO: read_word = aux_ratio_result;
                IDX_AVG_SETUP: read_word = averaging_setup_word;
                IDX_TEMP_GAIN: read_word = temp_gain_coef;
                IDX_TEMP_OFFSET: read_word = temp_offset_coef;
                default: read_word = RST_ZERO;
            endcase
        end
    end

    // The whole word is caught in the setup cycle and held through the access,
    // so both bytes come from the same instant.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= {16'h0000, read_word}; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TEX_HOLD: assert property ( // R1
        (state == ST_CONV) && tex && !temp_wr |=> $stable(temperature))
        else $error("Conversion wrote temperature in external mode.");

    AST_AUX_SAMPLE: assert property ( // R3
        (state == ST_SAMPLE) && !abort |=> aux_ratio_result == $past(aux_data))
        else $error("Aux sample was not stored.");

    AST_AUX_HOLD: assert property ( // R4
        abort |=> $stable(aux_ratio_result) [*2])
        else $error("Aux result moved while disabled.");

    AST_TEMP_CONV: assert property ( // R5
        conv_fire && !tex |=> temperature == $past(next_temp))
        else $error("Temperature differs from converted value.");

    AST_MEAN_SHDN: assert property ( // R9
        shdn && !temp_wr |=> $stable(mean_acc))
        else $error("Mean moved during shutdown.");

    AST_PEAK_HIGH: assert property ( // R10
        temp_upd |=> $signed(temp_peak_high) >= $signed($past(upd_byte)))
        else $error("High peak below latest reading.");

    AST_PEAK_LOW: assert property ( // R10
        temp_upd |=> $signed(temp_peak_low) <= $signed($past(upd_byte)))
        else $error("Low peak above latest reading.");

    AST_PEAK_CLEAR: assert property ( // R11
        peak_wr && wdata == RST_PEAK_REC && !temp_upd |=>
        {temp_peak_high, temp_peak_low} == RST_PEAK_REC)
        else $error("Peak record not cleared.");

    AST_READ_HOLD: assert property ( // R15
        rd_setup ##1 (psel && penable) |=> $stable(prdata))
        else $error("Read data changed during access.");

    AST_BIAS_SETTLE: assert property ( // R18
        $rose(state == ST_SETTLE) |-> thermistor_bias_pin)
        else $error("Divider not biased while settling.");

    AST_BIAS_OFF: assert property ( // R18
        state == ST_IDLE && next_state == ST_IDLE |=> !thermistor_bias_pin)
        else $error("Divider biased while idle.");

    COV_CONVERSION: cover property (conv_fire && !tex);
    COV_EXT_WRITE: cover property (temp_wr && tex);
    COV_PEAK_CLEAR: cover property (peak_wr && wdata == RST_PEAK_REC);
    COV_ABORT: cover property ((state == ST_SETTLE) ##1 abort);

endmodule : thermistor_temperature_readout

// ---- thermistor_pkg.sv ----
// Constants, register map and state codes for the thermistor temperature readout.
//
// What this block does
// R1 - External select stops conversion writes to temperature
// R2 - Host then writes temperature periodically itself
// R3 - Store ratiometric aux result every conversion period
// R4 - Aux result holds in shutdown or disabled
// R5 - Convert aux to signed temperature each period
// R6 - Temperature upper byte is whole-degree value
// R7 - Temperature holds its value through shutdown; a host write to the word still lands during shutdown
// R8 - Keep running mean over configurable window
// R9 - First reading seeds mean; shutdown holds it
// R10 - Each update refreshes high and low peaks
// R11 - Peaks reset to 80h/7Fh; host clears
// R12 - Peaks are signed bytes packed in one word
// R13 - Temperature equals aux*gain/16384 plus twice offset
// R14 - Linear space of 256 sixteen-bit words
// R15 - Read word is latched whole for the read
// R16 - Registers load defaults, keep through shutdown
// R17 - Reserved words read undefined, host avoids writes
// R18 - Bias divider, settle, then sample aux input
// R19 - Host temperature write overwritten by next conversion
package thermistor_pkg;
    // Clock rate and the conversion period in their own units.
    localparam int unsigned CLK_KHZ = 25000;
    localparam int unsigned CONV_PERIOD_MS = 1400;
    localparam int unsigned CONV_CYCLES = CLK_KHZ * CONV_PERIOD_MS;
    // Divider settling time before sampling; least time rounds up.
    localparam int unsigned SETTLE_US = 8;
    localparam int unsigned SETTLE_CYCLES = (CLK_KHZ * SETTLE_US + 999) / 1000;
    // Word indices; the byte address is four times the index.
    localparam logic [7:0] IDX_HYP_LOAD = 8'h04;
    localparam logic [7:0] IDX_REM_CAP = 8'h05;
    localparam logic [7:0] IDX_CHG_PCT = 8'h06;
    localparam logic [7:0] IDX_CELL_AGE = 8'h07;
    localparam logic [7:0] IDX_TEMPERATURE = 8'h08;
    localparam logic [7:0] IDX_CELL_VOLT = 8'h09;
    localparam logic [7:0] IDX_SENSE_CUR = 8'h0A;
    localparam logic [7:0] IDX_MEAN_CUR = 8'h0B;
    localparam logic [7:0] IDX_BLEND_PCT = 8'h0D;
    localparam logic [7:0] IDX_AVAIL_PCT = 8'h0E;
    localparam logic [7:0] IDX_BLEND_CAP = 8'h0F;
    localparam logic [7:0] IDX_TEMP_MEAN = 8'h16;
    localparam logic [7:0] IDX_PEAK_REC = 8'h1A;
    localparam logic [7:0] IDX_CONFIG = 8'h1D;
    localparam logic [7:0] IDX_AUX_RATIO = 8'h27;
    localparam logic [7:0] IDX_AVG_SETUP = 8'h29;
    localparam logic [7:0] IDX_TEMP_GAIN = 8'h2C;
    localparam logic [7:0] IDX_TEMP_OFFSET = 8'h2D;
    // Power-on values, indexed 0..4 for the low control words.
    localparam logic [15:0] MISC_RESET [5] = '{16'h0002, 16'hFF00, 16'h7F80,
        16'hFF00, 16'h0000};
    localparam logic [15:0] RST_REM_CAP = 16'h03E8;
    localparam logic [15:0] RST_PCT = 16'h3200;
    localparam logic [15:0] RST_CELL_AGE = 16'h6400;
    localparam logic [15:0] RST_TEMPERATURE = 16'h1600;
    localparam logic [15:0] RST_CELL_VOLT = 16'hB400;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_PEAK_REC = 16'h807F;
    localparam logic [15:0] RST_CONFIG = 16'h0200;
    localparam logic [15:0] RST_AUX_RATIO = 16'h88D0;
    localparam logic [15:0] RST_AVG_SETUP = 16'h4EA4;
    localparam logic [15:0] RST_TEMP_GAIN = 16'hE3E1;
    localparam logic [15:0] RST_TEMP_OFFSET = 16'h290E;
    // Configuration fields.
    localparam int unsigned CFG_TEN_BIT = 9;
    localparam int unsigned CFG_TEX_BIT = 8;
    localparam int unsigned CFG_SHDN_BIT = 7;
    localparam int unsigned AVG_SHIFT_LSB = 11;
    localparam logic [4:0] AVG_SHIFT_BASE = 5'h08;
    // Gain divides by 16384, a shift of fourteen.
    localparam int unsigned GAIN_SHIFT = 14;
    // One-hot conversion sequence states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_CONV = 4'b1000
    } conv_state_t;
endpackage : thermistor_pkg

// ---- aux_front_end.sv ----
// Behavioural model of the thermistor divider and aux converter at the far side.
`timescale 1ns/10ps
module aux_front_end (
    input wire logic pclk, // System clock.
    input wire logic thermistor_bias_pin, // High while the divider is powered.
    input wire logic [15:0] aux_level, // Ratio that a settled divider would give.
    output logic [15:0] aux_data // Converter result seen by the block.
);
    ////////////////////////////////////////////////////////////////////////////
    // An unpowered divider gives no usable ratio, so the output churns every
    // cycle; a block that samples outside the biased window reads garbage.
    initial aux_data = 16'h0000;
    always @(posedge pclk) begin
        if (thermistor_bias_pin) begin
            aux_data <= aux_level;
        end else begin
            aux_data <= ~aux_data;
        end
    end
endmodule : aux_front_end

// ---- thermistor_temperature_readout_tb.sv ----
// Self-checking testbench for the thermistor temperature readout.
`timescale 1ns/10ps
module thermistor_temperature_readout_tb;
    import thermistor_pkg::*;
    localparam int unsigned CONV = 200; // Shortened period keeps the run brief.
    localparam logic [7:0] RI [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h1A, 8'h2C, 8'h2D,
        8'h16, 8'h1D, 8'h27, 8'h29};
    localparam logic [15:0] RV [22] = '{16'h0002, 16'hFF00, 16'h7F80, 16'hFF00,
        16'h0000, 16'h03E8, 16'h3200, 16'h6400, 16'h1600, 16'hB400, 16'h0000,
        16'h0000, 16'h3200, 16'h3200, 16'h03E8, 16'h807F, 16'hE3E1, 16'h290E,
        16'h1600, 16'h0200, 16'h88D0, 16'h4EA4};
    localparam logic [15:0] CG [3] = '{16'h4000, 16'h4000, 16'hE3E1}; // Gains.
    localparam logic [15:0] CO [3] = '{16'h0000, 16'h0000, 16'h290E}; // Offsets.
    localparam logic [15:0] CL [3] = '{16'h2300, 16'h1000, 16'h4000}; // Ratios.
    logic pclk = 1'b0; // Bench clock.
    logic presetn = 1'b0; // Reset, active low.
    logic psel = 1'b0; // APB select.
    logic penable = 1'b0; // APB access phase.
    logic pwrite = 1'b0; // APB direction.
    logic [9:0] paddr = 10'h000; // APB byte address.
    logic [31:0] pwdata = 32'h0000_0000; // APB write data.
    logic [31:0] prdata; // APB read data.
    logic pready; // APB ready.
    logic pslverr; // APB error.
    logic [15:0] aux_data; // Converter result.
    logic [15:0] aux_level = 16'h2300; // Ratio the model presents.
    logic thermistor_bias_pin; // Divider bias.
    logic bias_d = 1'b0; // Bias one cycle back.
    int bias_rises = 0; // Conversions started.
    int fail_count = 0; // Mismatches seen.
    int checked = 0; // Comparisons made.
    logic last_err; // Error flag of the latest transfer.

    thermistor_temperature_readout #(.CONV_TICKS(CONV), .SETTLE_TICKS(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .aux_data(aux_data),
        .thermistor_bias_pin(thermistor_bias_pin));
    aux_front_end i_front (.pclk(pclk), .thermistor_bias_pin(thermistor_bias_pin),
        .aux_level(aux_level), .aux_data(aux_data));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and a counter of bias pulses, which shows whether conversions run.
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        bias_d <= thermistor_bias_pin;
        if (thermistor_bias_pin === 1'b1 && bias_d === 1'b0) begin
            bias_rises <= bias_rises + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One APB transfer; it is entered just after a rising edge.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
        output logic [15:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[15:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] dummy;
        xfer(1'b1, idx, d, dummy);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        xfer(1'b0, idx, 16'h0000, d);
        check(d, exp);
    endtask : rd_chk

    // Waits out one bias pulse, then the edges that land the results.
    task automatic wait_conv();
        int n;
        n = 0;
        while (thermistor_bias_pin !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        while (thermistor_bias_pin === 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 1000) begin
            $display("unexpected at %0t: got %h expected %h", $time, n, 1000);
            fail_count++;
        end
        repeat (3) @(posedge pclk);
    endtask : wait_conv

    // Expected temperature: ratio times signed gain over 16384, plus twice offset.
    function automatic logic [15:0] tcalc(input logic [15:0] a, g, o);
        logic signed [32:0] p;
        p = $signed({1'b0, a}) * $signed(g);
        return p[29:14] + {o[14:0], 1'b0};
    endfunction : tcalc

    // Expected peak record after one temperature update.
    task automatic peak(input logic [15:0] t, inout logic signed [7:0] hi, lo);
        if ($signed(t[15:8]) > hi) hi = t[15:8];
        if ($signed(t[15:8]) < lo) lo = t[15:8];
    endtask : peak

    task automatic stop_test();
        $display("counts: checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////
    // A hang costs a mismatch; the tests need a few thousand cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [15:0] t, m;
        logic signed [7:0] hi, lo;
        int r;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 22; i++) rd_chk(RI[i], RV[i]);
        wr(IDX_REM_CAP, 16'h1234);
        rd_chk(IDX_REM_CAP, 16'h03E8);
        wr(8'h0C, 16'h5555);
        xfer(1'b0, 8'hF0, 16'h0000, t);
        check({15'h0000, last_err}, 16'h0000);
        $display("test reset values done");
        hi = 8'h80;
        lo = 8'h7F;
        for (int c = 0; c < 3; c++) begin
            wr(IDX_TEMP_GAIN, CG[c]);
            wr(IDX_TEMP_OFFSET, CO[c]);
            aux_level <= CL[c];
            wait_conv();
            t = tcalc(CL[c], CG[c], CO[c]);
            peak(t, hi, lo);
            rd_chk(IDX_AUX_RATIO, CL[c]);
            rd_chk(IDX_TEMPERATURE, t);
            rd_chk(IDX_PEAK_REC, {hi, lo});
            if (c == 0) rd_chk(IDX_TEMP_MEAN, t);
            if (c == 1) rd_chk(IDX_TEMP_MEAN, 16'h22F6);
            $display("test conversion %0d done", c);
        end
        // With external select the host owns the temperature word.
        wr(IDX_CONFIG, 16'h0300);
        wr(IDX_TEMPERATURE, 16'h0A00);
        peak(16'h0A00, hi, lo);
        aux_level <= 16'h3000;
        wait_conv();
        rd_chk(IDX_TEMPERATURE, 16'h0A00);
        rd_chk(IDX_AUX_RATIO, 16'h3000);
        rd_chk(IDX_PEAK_REC, {hi, lo});
        wr(IDX_PEAK_REC, 16'h807F);
        rd_chk(IDX_PEAK_REC, 16'h807F);
        wr(IDX_TEMPERATURE, 16'h0500);
        rd_chk(IDX_PEAK_REC, 16'h0505);
        $display("test external temperature done");
        // Shutdown, then disable: nothing converts and every value holds.
        xfer(1'b0, IDX_TEMP_MEAN, 16'h0000, m);
        wr(IDX_CONFIG, 16'h0280);
        aux_level <= 16'h1111;
        r = bias_rises;
        repeat (2 * CONV + 20) @(posedge pclk);
        check(16'(bias_rises - r), 16'h0000);
        rd_chk(IDX_AUX_RATIO, 16'h3000);
        rd_chk(IDX_TEMPERATURE, 16'h0500);
        rd_chk(IDX_TEMP_MEAN, m);
        rd_chk(IDX_PEAK_REC, 16'h0505);
        wr(IDX_CONFIG, 16'h0000);
        repeat (2 * CONV + 20) @(posedge pclk);
        rd_chk(IDX_AUX_RATIO, 16'h3000);
        $display("test shutdown done");
        // Back in conversion, a host write lasts only until the next result.
        hi = 8'h05;
        lo = 8'h05;
        wr(IDX_CONFIG, 16'h0200);
        wait_conv();
        t = tcalc(16'h1111, CG[2], CO[2]);
        peak(t, hi, lo);
        wr(IDX_TEMPERATURE, 16'h7700);
        peak(16'h7700, hi, lo);
        rd_chk(IDX_TEMPERATURE, 16'h7700);
        wait_conv();
        rd_chk(IDX_TEMPERATURE, t);
        rd_chk(IDX_PEAK_REC, {hi, lo});
        $display("test overwrite done");
        stop_test();
    end
endmodule : thermistor_temperature_readout_tb
